/* hw/tsm_pkg.sv */
// Behaviour
// - Split mode turns timer 0 register into two independent 8-bit counters.
// - Low byte uses timer 0 run, source select, gate and overflow flag.
// - Low byte counts system or prescaled clock ticks or falling counter-pin edges.
// - High byte is timer only: system or prescaled clock, never a pin.
// - High byte advances only while timer 1 run bit is set.
// - High byte overflow sets timer 1 overflow flag, raising its interrupt.
// - Timer 1 runs modes 0-2 in split mode, no pin, flag or interrupt.
// - Timer 1 overflow still feeds baud ticks and converter start trigger.
// - In split mode timer 1 runs in modes 0-2, stops in mode 3.
// - Timer 1 mode 3 means timer 1 inactive and not counting.
// - Setting a run bit never clears or reloads the count.
// - Gate set: count only while run set and interrupt input active, except timer 1 and the high byte in split mode.
package tsm_pkg;
    localparam logic [7:0] TRFC_ADDR   = 8'h88;
    localparam logic [7:0] TIMER_MODE_SELECT_REG_ADDR   = 8'h89;
    localparam logic [7:0] CKSEL_ADDR  = 8'h8e;
    localparam logic [7:0] POL_ADDR    = 8'h8f;
    localparam logic [7:0] CNT_ADDR0   = 8'h8a;
    localparam logic [7:0] CNT_ADDR1   = 8'h8b;
    localparam logic [7:0] CNT_ADDR2   = 8'h8c;
    localparam logic [7:0] CNT_ADDR3   = 8'h8d;
    localparam logic [7:0] IRQ_ST_ADDR = 8'h90;
    localparam logic [7:0] IRQ_MK_ADDR = 8'h91;
    localparam logic [7:0] RST_VAL     = 8'h00;
    // Control register bit positions
    localparam int B_TF1 = 7;
    localparam int B_TR1 = 6;
    localparam int B_TF0 = 5;
    localparam int B_TR0 = 4;
    localparam int B_IE1 = 3;
    localparam int B_IT1 = 2;
    localparam int B_IE0 = 1;
    localparam int B_IT0 = 0;
    // Mode register bit positions
    localparam int B_GATE1 = 7;
    localparam int B_CT1   = 6;
    localparam int B_M1HI  = 5;
    localparam int B_M1LO  = 4;
    localparam int B_PIN_GATING_ENABLE_ZERO = 3;
    localparam int B_CT0   = 2;
    localparam int B_M0HI  = 1;
    localparam int B_M0LO  = 0;
    // Clock select bits
    localparam int B_T0SYS = 0;
    localparam int B_T1SYS = 1;
    localparam int B_PRE_LO = 2;
    localparam int B_PRE_HI = 3;
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_8R = 2'h2;
    localparam logic [1:0] MODE_SP = 2'h3;
    localparam logic [7:0] BYTE_MAX = 8'hff;
    localparam logic [4:0] LOW5_MAX = 5'h1f;
    // Prescale divisors selected by two bits
    localparam logic [5:0] PRE_DIV12 = 6'd11;
    localparam logic [5:0] PRE_DIV4  = 6'd3;
    localparam logic [5:0] PRE_DIV48 = 6'd47;
    localparam logic [5:0] PRE_DIV8  = 6'd7;
    // Interrupt status bits
    localparam int S_OV0 = 0;
    localparam int S_OV1 = 1;
    localparam int S_EX0 = 2;
    localparam int S_EX1 = 3;
    localparam int NSTAT = 4;
endpackage

/* hw/tsm_tick_if.sv */
`timescale 1ns/1ps
interface tsm_tick_if;
    logic       cnt_en;
    logic       load;
    logic [1:0] mode;
    logic [7:0] wdata;
    logic       sel_hi;
    logic [7:0] low_q;
    logic [7:0] high_q;
    logic       ovf_low;
    logic       ovf_high;
    modport ctl (output cnt_en, load, mode, wdata, sel_hi, input low_q, high_q, ovf_low, ovf_high);
    modport cnt (input cnt_en, load, mode, wdata, sel_hi, output low_q, high_q, ovf_low, ovf_high);
endinterface

/* hw/tsm_counter.sv */
`timescale 1ns/1ps
// One 16-bit timer register in modes 0-2; overflow is combinational
module tsm_counter
    import tsm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    tsm_tick_if.cnt   bus
);
    logic [7:0] low_r;
    logic [7:0] high_r;
    always_comb begin
        bus.low_q    = low_r;
        bus.high_q   = high_r;
        bus.ovf_high = 1'b0;
        unique case (bus.mode)
            MODE_13: bus.ovf_low = bus.cnt_en && low_r[4:0] == LOW5_MAX && high_r == BYTE_MAX;
            MODE_16: bus.ovf_low = bus.cnt_en && low_r == BYTE_MAX && high_r == BYTE_MAX;
            MODE_8R: bus.ovf_low = bus.cnt_en && low_r == BYTE_MAX;
            MODE_SP: bus.ovf_low = 1'b0;
        endcase
    end
    // Count held across run toggles; only loads and enabled counting change it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_r  <= RST_VAL;
            high_r <= RST_VAL;
        end else if (bus.load) begin
            if (bus.sel_hi) high_r <= bus.wdata;
            else low_r <= bus.wdata;
        end else if (bus.cnt_en) begin
            unique case (bus.mode)
                MODE_13: begin
                    low_r[4:0] <= low_r[4:0] + 5'h1;
                    if (low_r[4:0] == LOW5_MAX) high_r <= high_r + 8'h1;
                end
                MODE_16: begin
                    low_r <= low_r + 8'h1;
                    if (low_r == BYTE_MAX) high_r <= high_r + 8'h1;
                end
                MODE_8R: low_r <= (low_r == BYTE_MAX) ? high_r : low_r + 8'h1;
                MODE_SP: ;
            endcase
        end
    end
endmodule

/* hw/tsm_ext_flag.sv */
`timescale 1ns/1ps
// External interrupt flag with pin sampling and polarity
module tsm_ext_flag
    import tsm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic pol_i,
    input  wire logic edge_mode_i,
    input  wire logic vec_clr_i,
    input  wire logic sw_clr_i,
    output logic      active_o,
    output logic      flag_o,
    output logic      set_o
);
    logic [2:0] sync_r;
    logic       act_r;
    logic       flag_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) sync_r <= 3'h0;
        else sync_r <= {sync_r[1:0], pin_i};
    end
    // Stage one is read only by stage two; change counted when 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (rst_i) act_r <= 1'b0;
        else if (sync_r[1] == sync_r[2]) act_r <= sync_r[2] ~^ pol_i;
    end
    wire act_nxt = (sync_r[1] == sync_r[2]) ? (sync_r[2] ~^ pol_i) : act_r;
    assign set_o = edge_mode_i ? (act_nxt && !act_r) : act_r;
    // Set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) flag_r <= 1'b0;
        else if (!edge_mode_i) flag_r <= act_r;
        else if (set_o) flag_r <= 1'b1;
        else if (vec_clr_i || sw_clr_i) flag_r <= 1'b0;
    end
    assign active_o = act_r;
    assign flag_o   = flag_r;
endmodule

/* hw/tsm_top.sv */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module tsm_top
    import tsm_pkg::*;
(
    input  wire logic       CLK_SYS_I,
    input  wire logic       RST_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    input  wire logic       CNT_PIN0_I,
    input  wire logic       CNT_PIN1_I,
    input  wire logic       EXT_IRQ_INPUT_ZERO_I,
    input  wire logic       EXT_IRQ_INPUT_ONE_I,
    input  wire logic       VEC_T0_I,
    input  wire logic       VEC_T1_I,
    input  wire logic       VEC_EX0_I,
    input  wire logic       VEC_EX1_I,
    output logic            T0_IRQ_O,
    output logic            T1_IRQ_O,
    output logic            EX0_IRQ_O,
    output logic            EX1_IRQ_O,
    output logic            BAUD_TICK_O,
    output logic            CONV_START_O,
    output logic            IRQ_O
);
    logic [7:0] ctl_r;
    logic [7:0] mode_r;
    logic [3:0] cksel_r;
    logic [1:0] pol_r;
    logic [NSTAT-1:0] stat_r;
    logic [NSTAT-1:0] mask_r;
    logic [5:0] pre_r;
    logic       pre_tick;
    logic [2:0] p0_r;
    logic [2:0] p1_r;
    logic       p0_lvl_r;
    logic       p1_lvl_r;
    logic       p0_fall;
    logic       p1_fall;
    logic       ex0_act;
    logic       ex1_act;
    logic       ex0_flag;
    logic       ex1_flag;
    logic       ex0_set;
    logic       ex1_set;
    tsm_tick_if t0_if ();
    tsm_tick_if t1_if ();

    function automatic logic wr_hit(input logic [7:0] a);
        return WR_I && ADDR_I == a;
    endfunction

    wire split = mode_r[B_M0HI:B_M0LO] == MODE_SP;
    wire [1:0] t1_mode = mode_r[B_M1HI:B_M1LO];

    // Prescaler
    logic [5:0] pre_div;
    always_comb begin
        unique case (cksel_r[B_PRE_HI:B_PRE_LO])
            2'h0: pre_div = PRE_DIV12;
            2'h1: pre_div = PRE_DIV4;
            2'h2: pre_div = PRE_DIV48;
            2'h3: pre_div = PRE_DIV8;
        endcase
    end
    assign pre_tick = pre_r == pre_div;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || pre_tick) pre_r <= 6'h0;
        else pre_r <= pre_r + 6'h1;
    end

    // Counter pins: three stages, change taken once stages 2 and 3 agree
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            p0_r <= 3'h0;
            p1_r <= 3'h0;
        end else begin
            p0_r <= {p0_r[1:0], CNT_PIN0_I};
            p1_r <= {p1_r[1:0], CNT_PIN1_I};
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            p0_lvl_r <= 1'b0;
            p1_lvl_r <= 1'b0;
        end else begin
            if (p0_r[1] == p0_r[2]) p0_lvl_r <= p0_r[2];
            if (p1_r[1] == p1_r[2]) p1_lvl_r <= p1_r[2];
        end
    end
    // Level resets low: an idle-high pin first shows a rise, never a false fall
    assign p0_fall = p0_lvl_r && p0_r[1] == p0_r[2] && !p0_r[2];
    assign p1_fall = p1_lvl_r && p1_r[1] == p1_r[2] && !p1_r[2];

    tsm_ext_flag u_ex0 (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RST_I),
        .pin_i      (EXT_IRQ_INPUT_ZERO_I),
        .pol_i      (pol_r[0]),
        .edge_mode_i(ctl_r[B_IT0]),
        .vec_clr_i  (VEC_EX0_I),
        .sw_clr_i   (wr_hit(TRFC_ADDR) && !WDATA_I[B_IE0]),
        .active_o   (ex0_act),
        .flag_o     (ex0_flag),
        .set_o      (ex0_set)
    );
    tsm_ext_flag u_ex1 (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RST_I),
        .pin_i      (EXT_IRQ_INPUT_ONE_I),
        .pol_i      (pol_r[1]),
        .edge_mode_i(ctl_r[B_IT1]),
        .vec_clr_i  (VEC_EX1_I),
        .sw_clr_i   (wr_hit(TRFC_ADDR) && !WDATA_I[B_IE1]),
        .active_o   (ex1_act),
        .flag_o     (ex1_flag),
        .set_o      (ex1_set)
    );

    // Timer 0 low byte / whole timer 0
    wire t0_run  = ctl_r[B_TR0] && (!mode_r[B_PIN_GATING_ENABLE_ZERO] || ex0_act);
    wire t0_clk  = cksel_r[B_T0SYS] ? 1'b1 : pre_tick;
    wire t0_tick = mode_r[B_CT0] ? p0_fall : t0_clk;
    wire t0_en   = t0_run && t0_tick;
    // High byte in split mode: timer only, run by timer 1 run bit
    wire th_en   = split && ctl_r[B_TR1] && t0_clk;
    // Timer 1: in split mode no pin, no gate, runs by mode field only
    wire t1_clk  = cksel_r[B_T1SYS] ? 1'b1 : pre_tick;
    wire t1_run  = split ? 1'b1
                         : ctl_r[B_TR1] && (!mode_r[B_GATE1] || ex1_act);
    wire t1_tick = (mode_r[B_CT1] && !split) ? p1_fall : t1_clk;
    wire t1_en   = t1_run && t1_tick && t1_mode != MODE_SP;

    logic [7:0] th_r;
    logic       lo_ovf;
    assign lo_ovf = split && t0_en && t0_if.low_q == BYTE_MAX;

    assign t0_if.cnt_en = t0_en && !split;
    assign t0_if.mode   = mode_r[B_M0HI:B_M0LO];
    // Software write beats the split-mode step that falls in the same cycle
    wire t0_sw_wr = wr_hit(CNT_ADDR0) || (!split && wr_hit(CNT_ADDR1));
    assign t0_if.wdata  = t0_sw_wr ? WDATA_I : t0_if.low_q + 8'h1;
    assign t0_if.sel_hi = t0_sw_wr && ADDR_I == CNT_ADDR1;
    assign t0_if.load   = t0_sw_wr || (split && t0_en);
    assign th_r = t0_if.high_q;
    tsm_counter u_t0 (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .bus  (t0_if.cnt)
    );
    // Split high byte kept beside the low byte's register
    logic [7:0] sp_hi_r;
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) sp_hi_r <= RST_VAL;
        else if (wr_hit(CNT_ADDR1)) sp_hi_r <= WDATA_I;
        else if (th_en) sp_hi_r <= sp_hi_r + 8'h1;
    end

    assign t1_if.cnt_en = t1_en;
    assign t1_if.mode   = t1_mode;
    assign t1_if.wdata  = WDATA_I;
    assign t1_if.sel_hi = ADDR_I == CNT_ADDR3;
    assign t1_if.load   = wr_hit(CNT_ADDR2) || wr_hit(CNT_ADDR3);
    tsm_counter u_t1 (
        .clk_i(CLK_SYS_I),
        .rst_i(RST_I),
        .bus  (t1_if.cnt)
    );

    wire ov0 = split ? lo_ovf : t0_if.ovf_low;
    wire ov1_hi = split && th_en && sp_hi_r == BYTE_MAX;
    wire ov1 = split ? ov1_hi : t1_if.ovf_low;
    wire trfc_wr = wr_hit(TRFC_ADDR);

    // Control register: overflow set beats software or vector clear
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) ctl_r <= RST_VAL;
        else begin
            if (trfc_wr) begin
                ctl_r[B_TR1] <= WDATA_I[B_TR1];
                ctl_r[B_TR0] <= WDATA_I[B_TR0];
                ctl_r[B_IT1] <= WDATA_I[B_IT1];
                ctl_r[B_IT0] <= WDATA_I[B_IT0];
            end
            if (ov0) ctl_r[B_TF0] <= 1'b1;
            else if (VEC_T0_I) ctl_r[B_TF0] <= 1'b0;
            else if (trfc_wr) ctl_r[B_TF0] <= WDATA_I[B_TF0];
            if (ov1) ctl_r[B_TF1] <= 1'b1;
            else if (VEC_T1_I) ctl_r[B_TF1] <= 1'b0;
            else if (trfc_wr) ctl_r[B_TF1] <= WDATA_I[B_TF1];
            // Event bits are copies; a written zero reaches the flag module instead
            ctl_r[B_IE0] <= ex0_flag;
            ctl_r[B_IE1] <= ex1_flag;
        end
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            mode_r  <= RST_VAL;
            cksel_r <= 4'h0;
            pol_r   <= 2'h0;
        end else begin
            if (wr_hit(TIMER_MODE_SELECT_REG_ADDR)) mode_r <= WDATA_I;
            if (wr_hit(CKSEL_ADDR)) cksel_r <= WDATA_I[3:0];
            if (wr_hit(POL_ADDR)) pol_r <= WDATA_I[1:0];
        end
    end

    // Sticky event status, write one to clear, set wins
    wire [NSTAT-1:0] ev = {ex1_set, ex0_set, ov1, ov0};
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            stat_r <= ev | (stat_r & ~(wr_hit(IRQ_ST_ADDR) ? WDATA_I[NSTAT-1:0] : '0));
            if (wr_hit(IRQ_MK_ADDR)) mask_r <= WDATA_I[NSTAT-1:0];
        end
    end

    logic [7:0] rd_nxt;
    always_comb begin
        unique case (ADDR_I)
            TRFC_ADDR:   rd_nxt = ctl_r;
            TIMER_MODE_SELECT_REG_ADDR:   rd_nxt = mode_r;
            CKSEL_ADDR:  rd_nxt = {4'h0, cksel_r};
            POL_ADDR:    rd_nxt = {6'h0, pol_r};
            CNT_ADDR0:   rd_nxt = t0_if.low_q;
            CNT_ADDR1:   rd_nxt = split ? sp_hi_r : th_r;
            CNT_ADDR2:   rd_nxt = t1_if.low_q;
            CNT_ADDR3:   rd_nxt = t1_if.high_q;
            IRQ_ST_ADDR: rd_nxt = {4'h0, stat_r};
            IRQ_MK_ADDR: rd_nxt = {4'h0, mask_r};
            default:     rd_nxt = 8'h00;
        endcase
    end
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            RDATA_O      <= 8'h00;
            T0_IRQ_O     <= 1'b0;
            T1_IRQ_O     <= 1'b0;
            EX0_IRQ_O    <= 1'b0;
            EX1_IRQ_O    <= 1'b0;
            BAUD_TICK_O  <= 1'b0;
            CONV_START_O <= 1'b0;
            IRQ_O        <= 1'b0;
        end else begin
            RDATA_O      <= RD_I ? rd_nxt : 8'h00;
            T0_IRQ_O     <= ctl_r[B_TF0];
            T1_IRQ_O     <= ctl_r[B_TF1];
            EX0_IRQ_O    <= ex0_flag;
            EX1_IRQ_O    <= ex1_flag;
            // Ticks leave in every mode of timer 0; only the flag is cut in split
            BAUD_TICK_O  <= t1_if.ovf_low;
            CONV_START_O <= t1_if.ovf_low;
            IRQ_O        <= |(stat_r & mask_r);
        end
    end

    a_split_hi_ovf: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        ov1_hi |=> ctl_r[B_TF1]) else $error("high byte overflow lost");
    a_t1_no_flag: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        split && !ov1_hi && !trfc_wr && !ctl_r[B_TF1] |=> !ctl_r[B_TF1])
        else $error("timer 1 flagged in split");
    a_mode3_stop: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        t1_mode == MODE_SP && !t1_if.load |=> $stable(t1_if.low_q))
        else $error("timer 1 counted in mode 3");
    a_hi_run_gate: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        split && !ctl_r[B_TR1] && !wr_hit(CNT_ADDR1) |=> $stable(sp_hi_r))
        else $error("high byte ran without run bit");
    a_gate_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        mode_r[B_PIN_GATING_ENABLE_ZERO] && !ex0_act && !t0_if.load |=> $stable(t0_if.low_q))
        else $error("gated timer counted");
    a_baud_tick: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        t1_if.ovf_low |=> BAUD_TICK_O && CONV_START_O)
        else $error("timer 1 tick missing");
    a_t0_ovf_set: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        ov0 |=> ctl_r[B_TF0]) else $error("timer 0 overflow lost");
    a_lo_counts: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        split && t0_en && !wr_hit(CNT_ADDR0) |=> t0_if.low_q == $past(t0_if.low_q) + 8'h1)
        else $error("low byte did not step");
    a_hi_steps: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        th_en && !wr_hit(CNT_ADDR1) |=> sp_hi_r == $past(sp_hi_r) + 8'h1)
        else $error("high byte did not step");
    a_run_resume: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        split && $rose(ctl_r[B_TR0]) && !wr_hit(CNT_ADDR0)
        |=> t0_if.low_q - $past(t0_if.low_q) <= 8'h1)
        else $error("run bit moved the count");
    a_t1_split_run: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        split && t1_mode != MODE_SP && cksel_r[B_T1SYS] && !t1_if.load && !t1_if.ovf_low
        |=> $changed(t1_if.low_q)) else $error("timer 1 idle in split");
    a_ex_level: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !ctl_r[B_IT1] |=> ex1_flag == $past(ex1_act)) else $error("level flag lags input");
    a_ex_edge_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        ctl_r[B_IT0] && ex0_flag && !VEC_EX0_I && !(trfc_wr && !WDATA_I[B_IE0])
        |=> ex0_flag) else $error("edge flag lost");
    c_split_ovf: cover property (@(posedge CLK_SYS_I) ov1_hi);
    c_lo_ovf: cover property (@(posedge CLK_SYS_I) lo_ovf);
    c_baud: cover property (@(posedge CLK_SYS_I) split && t1_if.ovf_low);
    c_vec_clr: cover property (@(posedge CLK_SYS_I) VEC_T0_I && ctl_r[B_TF0]);
    c_gated_run: cover property (@(posedge CLK_SYS_I) mode_r[B_PIN_GATING_ENABLE_ZERO] && t0_en);
endmodule

/* dv/tsm_cpu_model.sv */
`timescale 1ns/1ps
// Core side: vectors to a pending interrupt after a short or a slow delay
module tsm_cpu_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] irq_i,
    input  wire logic [3:0] ack_en_i,
    input  wire logic       slow_i,
    output logic      [3:0] vec_o
);
    for (genvar g = 0; g < 4; g++) begin : g_ch
        logic [2:0] dly_r;
        logic       busy_r;
        logic       vec_r;
        assign vec_o[g] = vec_r;
        // Busy until the request drops, so one request is served once only
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                dly_r  <= 3'h0;
                busy_r <= 1'b0;
                vec_r  <= 1'b0;
            end else begin
                vec_r <= 1'b0;
                if (!busy_r && irq_i[g] && ack_en_i[g]) begin
                    if (dly_r == (slow_i ? 3'h4 : 3'h0)) begin
                        vec_r  <= 1'b1;
                        busy_r <= 1'b1;
                        dly_r  <= 3'h0;
                    end else begin
                        dly_r <= dly_r + 3'h1;
                    end
                end else if (busy_r && !irq_i[g]) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end
endmodule

/* dv/tsm_top_tb.sv */
`timescale 1ns/1ps
module tsm_top_tb
    import tsm_pkg::*;
;
    logic       clk, rst, wr, rd, pin0, pin1, ext0, ext1, slow;
    logic [7:0] addr, wdata, rdata, v;
    logic [3:0] vec, irqs, ack_en;
    logic       baud, conv, irq;
    int         error_cnt, tests_run, cyc;

    tsm_top i_dut (
        .CLK_SYS_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .CNT_PIN0_I(pin0), .CNT_PIN1_I(pin1),
        .EXT_IRQ_INPUT_ZERO_I(ext0), .EXT_IRQ_INPUT_ONE_I(ext1),
        .VEC_T0_I(vec[0]), .VEC_T1_I(vec[1]), .VEC_EX0_I(vec[2]), .VEC_EX1_I(vec[3]),
        .T0_IRQ_O(irqs[0]), .T1_IRQ_O(irqs[1]), .EX0_IRQ_O(irqs[2]),
        .EX1_IRQ_O(irqs[3]), .BAUD_TICK_O(baud), .CONV_START_O(conv), .IRQ_O(irq)
    );
    tsm_cpu_model i_cpu (
        .clk_i(clk), .rst_i(rst), .irq_i(irqs), .ack_en_i(ack_en),
        .slow_i(slow), .vec_o(vec)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Long enough for every wait below with a wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    function automatic logic pick(input int w);
        return (w < 4) ? irqs[w] : baud;
    endfunction

    task automatic wait_hi(input int w, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(posedge clk);
            #1;
            if (pick(w) === 1'b1) break;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    initial begin
        {wr, rd, pin1, ext0, ext1, slow} = '0;
        {addr, wdata} = '0;
        pin0 = 1'b1;
        ack_en = 4'h0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(TRFC_ADDR, v);
        chk("control reset", RST_VAL, v);
        rd_reg(TIMER_MODE_SELECT_REG_ADDR, v);
        chk("mode reset", 8'h00, v);
        chk("ext one level", 8'h01, irqs[3]);
        wr_reg(8'h95, 8'hff);
        rd_reg(8'h95, v);
        chk("unmapped read", 8'h00, v);
        // Split mode, both bytes on the system clock
        wr_reg(CKSEL_ADDR, 8'h03);
        wr_reg(TIMER_MODE_SELECT_REG_ADDR, 8'h03);
        wr_reg(CNT_ADDR0, 8'hf0);
        wr_reg(CNT_ADDR1, 8'hf8);
        wr_reg(TRFC_ADDR, 8'h10);
        wait_hi(0, 100);
        chk("low byte overflow irq", 8'h01, irqs[0]);
        rd_reg(TRFC_ADDR, v);
        chk("flag zero set", 8'h01, v[B_TF0]);
        chk("flag one idle", 8'h00, v[B_TF1]);
        rd_reg(CNT_ADDR1, v);
        chk("high byte held", 8'hf8, v);
        wr_reg(TRFC_ADDR, 8'h50);
        wait_hi(1, 100);
        chk("high byte overflow irq", 8'h01, irqs[1]);
        wr_reg(TRFC_ADDR, 8'h00);
        idle(3);
        chk("software clear", 8'h00, irqs[1]);
        // Status, mask and the summary line
        wr_reg(IRQ_MK_ADDR, 8'h01);
        idle(2);
        chk("masked summary", 8'h01, irq);
        wr_reg(IRQ_ST_ADDR, 8'h01);
        idle(2);
        chk("summary cleared", 8'h00, irq);
        // Run bit keeps the count
        wr_reg(CNT_ADDR0, 8'h40);
        wr_reg(TRFC_ADDR, 8'h10);
        rd_reg(CNT_ADDR0, v);
        chk("count resumed", 8'h01, v > 8'h40 && v < 8'h48);
        // Vectoring clears the flag, slow core
        slow <= 1'b1;
        ack_en <= 4'h1;
        wr_reg(CNT_ADDR0, 8'hfe);
        wait_hi(0, 50);
        idle(10);
        chk("vector clear", 8'h00, irqs[0]);
        wr_reg(TRFC_ADDR, 8'h00);
        ack_en <= 4'h0;
        // Falling pin edges counted
        wr_reg(TIMER_MODE_SELECT_REG_ADDR, 8'h07);
        wr_reg(CNT_ADDR0, 8'h10);
        wr_reg(TRFC_ADDR, 8'h10);
        repeat (5) begin
            @(posedge clk) pin0 <= 1'b0;
            idle(4);
            @(posedge clk) pin0 <= 1'b1;
            idle(4);
        end
        idle(8);
        wr_reg(TRFC_ADDR, 8'h00);
        rd_reg(CNT_ADDR0, v);
        chk("pin count", 8'h15, v);
        // Gate: input low holds the count, level flag follows input
        wr_reg(TIMER_MODE_SELECT_REG_ADDR, 8'h0b);
        wr_reg(POL_ADDR, 8'h01);
        wr_reg(CNT_ADDR0, 8'h20);
        wr_reg(TRFC_ADDR, 8'h10);
        idle(20);
        rd_reg(CNT_ADDR0, v);
        chk("gated hold", 8'h20, v);
        @(posedge clk) ext0 <= 1'b1;
        idle(10);
        chk("level flag high", 8'h01, irqs[2]);
        rd_reg(CNT_ADDR0, v);
        chk("gated run", 8'h01, v != 8'h20);
        @(posedge clk) ext0 <= 1'b0;
        idle(8);
        chk("level flag low", 8'h00, irqs[2]);
        // Edge mode: sticky until the core vectors
        wr_reg(TRFC_ADDR, 8'h01);
        @(posedge clk) ext0 <= 1'b1;
        idle(4);
        @(posedge clk) ext0 <= 1'b0;
        idle(8);
        chk("edge flag sticky", 8'h01, irqs[2]);
        slow <= 1'b0;
        ack_en <= 4'h4;
        idle(10);
        chk("edge flag vectored", 8'h00, irqs[2]);
        ack_en <= 4'h0;
        // Timer 1 under split mode: ticks only, no flag
        wr_reg(TIMER_MODE_SELECT_REG_ADDR, 8'h13);
        wr_reg(CNT_ADDR2, 8'hfc);
        wr_reg(CNT_ADDR3, 8'hff);
        wait_hi(4, 100);
        chk("baud tick", 8'h01, baud);
        chk("convert start", 8'h01, conv);
        rd_reg(TRFC_ADDR, v);
        chk("no timer one flag", 8'h00, v[B_TF1]);
        wr_reg(TIMER_MODE_SELECT_REG_ADDR, 8'h73);
        wr_reg(CNT_ADDR2, 8'hfc);
        wr_reg(CNT_ADDR3, 8'hff);
        // Pin noise too: mode 3 must ignore both clock and pin
        fork
            repeat (30) begin
                @(posedge clk) pin1 <= ~pin1;
                idle(4);
            end
            wait_hi(4, 140);
        join_any
        chk("timer one stopped", 8'h00, baud);
        rd_reg(CNT_ADDR2, v);
        chk("timer one held", 8'hfc, v);
        complete_run();
    end
endmodule
